// >>> logic/ettl_logger.sv
`timescale 1ns/1ps
module ettl_logger (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 event_pulse_input_i,
  input  wire logic [63:0]          time_now_i,
  input  wire logic                 port1_char_valid_i,
  input  wire logic [7:0]           port1_char_i,
  input  wire logic                 port2_char_valid_i,
  input  wire logic [7:0]           port2_char_i,
  input  wire logic                 view_req_i,
  input  wire logic [3:0]           view_index_i,
  input  wire logic                 read_events_command_i,
  output logic                      view_valid_o,
  output logic [63:0]               view_time_o,
  output logic                      out_valid_o,
  output logic [3:0]                out_index_o,
  output logic [63:0]               out_time_o,
  output logic                      out_done_o,
  output logic [3:0]                count_o,
  output logic                      busy_o
);
  // ============================================================
  // Storage and state.
  logic [63:0]          stack [ettl_pkg::DEPTH]; // Position one is stack[0].
  logic                 sync1;                   // First synchroniser stage.
  logic                 sync2;                   // Second synchroniser stage.
  logic                 sync3;                   // Delayed copy for edge detection.
  logic [63:0]          pin_time;                // Time caught at the edge.
  logic                 pin_pend;                // Pin time waiting to be pushed.
  ettl_pkg::ettl_state_t state;                  // Read-out state.
  logic [3:0]           rd_idx;                  // Next position to send.

  // ============================================================
  // Helpers.
  // Maps a position number, one through eight, to its slot in the stack array.
  // Position eight wraps through zero to the last slot in three-bit arithmetic.
  function automatic logic [2:0] pos_to_slot(input logic [3:0] pos);
    pos_to_slot = pos[2:0] - 3'h1;
  endfunction

  // ============================================================
  // Event decode.
  // A rising edge of the synchronised pin is the timing point of a pin event.
  wire rise      = sync2 & ~sync3;
  // A number-sign character on either port is a serial event mark.
  wire ser_mark  = (port1_char_valid_i && port1_char_i == ettl_pkg::MARK_CHAR) ||
                   (port2_char_valid_i && port2_char_i == ettl_pkg::MARK_CHAR);
  // The clear state owns the stack for one cycle.
  wire do_clear  = (state == ettl_pkg::ETTL_CLEAR);
  // A pin event wins over a serial mark in the same cycle; that mark is lost, so the
  // user's system should keep marks apart from pin pulses.
  wire push      = ~do_clear & (pin_pend | ser_mark);
  // The pin time was caught at the edge; a mark takes the time of its own cycle.
  wire [63:0] push_time = pin_pend ? pin_time : time_now_i;
  // The entry count saturates at eight once the oldest entry starts to drop.
  wire [3:0] next_count = (count_o == 4'h8) ? 4'h8 : count_o + 4'h1;
  // A view index must name a position from one to eight.
  wire view_ok   = (view_index_i >= 4'h1) && (view_index_i <= 4'h8);
  // Entry selected for the viewing port; zero for an index out of range.
  wire [63:0] view_sel = view_ok ? stack[pos_to_slot(view_index_i)] : ettl_pkg::TIME_CLEAR;
  // Entry selected for the read-out port.
  wire [63:0] send_sel = stack[pos_to_slot(rd_idx)];

  // Synchroniser and edge latch of the pulse input.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1    <= 1'b0;
      sync2    <= 1'b0;
      sync3    <= 1'b0;
      pin_time <= ettl_pkg::TIME_CLEAR;
    end else begin
      sync1 <= event_pulse_input_i;
      sync2 <= sync1;
      sync3 <= sync2;
      if (rise) begin
        pin_time <= time_now_i;
      end
    end
  end

  // Pending flag: a pin event held through a clear is pushed afterwards.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_pend <= 1'b0;
    end else if (rise) begin
      pin_pend <= 1'b1;
    end else if (!do_clear) begin
      pin_pend <= 1'b0;
    end
  end

  // Stack push with shift, or zeroing after a read-out.
  always_ff @(posedge clk_i) begin
    if (rst_i || do_clear) begin
      for (int i = 0; i < ettl_pkg::DEPTH; i++) begin
        stack[i] <= ettl_pkg::TIME_CLEAR;
      end
      count_o <= ettl_pkg::COUNT_RESET;
    end else if (push) begin
      stack[0] <= push_time;
      for (int i = 1; i < ettl_pkg::DEPTH; i++) begin
        stack[i] <= stack[i-1];
      end
      count_o <= next_count;
    end
  end

  // Read-out sequencer: sends positions one to eight, then clears.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= ettl_pkg::ETTL_IDLE;
      rd_idx      <= 4'h1;
      out_valid_o <= 1'b0;
      out_index_o <= 4'h0;
      out_time_o  <= ettl_pkg::TIME_CLEAR;
      out_done_o  <= 1'b0;
      busy_o      <= 1'b0;
    end else begin
      out_valid_o <= 1'b0;
      out_done_o  <= 1'b0;
      case (state)
        ettl_pkg::ETTL_IDLE: begin
          if (read_events_command_i) begin
            state  <= ettl_pkg::ETTL_SEND;
            rd_idx <= 4'h1;
            busy_o <= 1'b1;
          end
        end
        // Send positions one to eight, one per cycle, newest first.
        ettl_pkg::ETTL_SEND: begin
          out_valid_o <= 1'b1;
          out_index_o <= rd_idx;
          out_time_o  <= send_sel;
          if (rd_idx == 4'h8) begin
            state <= ettl_pkg::ETTL_CLEAR;
          end
          rd_idx <= rd_idx + 4'h1;
        end
        // Clear cycle: the storage process zeroes the stack while done is pulsed.
        default: begin
          out_done_o <= 1'b1;
          busy_o     <= 1'b0;
          state      <= ettl_pkg::ETTL_IDLE;
        end
      endcase
    end
  end

  // Viewing port: read only, never alters the stack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      view_valid_o <= 1'b0;
      view_time_o  <= ettl_pkg::TIME_CLEAR;
    end else begin
      view_valid_o <= view_req_i && view_ok;
      view_time_o  <= view_sel;
    end
  end

  // ============================================================
  // Checks.
  // A pin edge that meets no clear on its way to the stack.
  sequence pin_edge_s;
    $rose(sync2) && !do_clear ##1 !do_clear;
  endsequence
  // A read-out request accepted while the sequencer is idle.
  sequence read_start_s;
    read_events_command_i && state == ettl_pkg::ETTL_IDLE;
  endsequence
  // Eight answers back to back while the block reports itself busy.
  sequence send_burst_s;
    (out_valid_o && busy_o) [*8];
  endsequence
  // The closing cycle of a read-out: done pulsed, busy dropped, count emptied.
  sequence read_end_s;
    out_done_o && !busy_o && count_o == ettl_pkg::COUNT_RESET;
  endsequence
  pin_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    pin_edge_s |=> stack[0] == $past(time_now_i, 2))
    else $error("Pin edge time not pushed.");
  push_top_a: assert property (@(posedge clk_i) disable iff (rst_i)
    push |=> stack[0] == $past(push_time))
    else $error("Newest entry not at position one.");
  shift_a: assert property (@(posedge clk_i) disable iff (rst_i)
    push |=> stack[7] == $past(stack[6]))
    else $error("Stack did not shift.");
  count_max_a: assert property (@(posedge clk_i) disable iff (rst_i)
    count_o <= 4'h8)
    else $error("Entry count beyond eight.");
  mark_push_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ser_mark && !do_clear |-> push)
    else $error("Marker character not logged.");
  clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    out_valid_o && out_index_o == 4'h8 |=> stack[0] == ettl_pkg::TIME_CLEAR
                                           && count_o == 4'h0 && out_done_o)
    else $error("Stack not zeroed after read-out.");
  hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !push && !do_clear |=> stack[0] == $past(stack[0]))
    else $error("Stack changed without event.");
  reset_a: assert property (@(posedge clk_i)
    rst_i |=> count_o == 4'h0 && stack[7] == ettl_pkg::TIME_CLEAR)
    else $error("Reset did not clear stack.");
  read_seq_a: assert property (@(posedge clk_i) disable iff (rst_i)
    read_start_s |=> busy_o ##1 send_burst_s ##1 read_end_s)
    else $error("Read-out did not send eight entries then finish.");
  out_index_a: assert property (@(posedge clk_i) disable iff (rst_i)
    out_valid_o && out_index_o != 4'h8
      |=> out_valid_o && out_index_o == $past(out_index_o) + 4'h1)
    else $error("Read-out positions not sent in order.");
  view_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    view_req_i && view_ok && !push && !do_clear
      |=> view_valid_o && view_time_o == stack[pos_to_slot($past(view_index_i))])
    else $error("Viewed entry differs from the stack.");
endmodule

// >>> logic/ettl_pkg.sv
// ============================================================
// Shared constants for the event time-tag logger.
package ettl_pkg;
  // Width of one full date and time value, counted in microseconds.
  localparam int unsigned TIME_W = 64;
  // Number of stack positions.
  localparam int unsigned DEPTH = 8;
  // Width of a stack position index, one through eight.
  localparam int unsigned IDX_W = 4;
  // Width of a serial character.
  localparam int unsigned CHAR_W = 8;
  // Character that marks an event on a serial port.
  localparam logic [7:0] MARK_CHAR = 8'h23;
  // Value of an emptied stack position.
  localparam logic [63:0] TIME_CLEAR = 64'h0000000000000000;
  // Value of the entry count after reset.
  localparam logic [3:0] COUNT_RESET = 4'h0;
  // Cycles from a pin rising edge to the time being written.
  localparam int unsigned PIN_LATENCY = 3;
  // Read-out states.
  typedef enum logic [1:0] {ETTL_IDLE, ETTL_SEND, ETTL_CLEAR} ettl_state_t;
endpackage

// >>> verification/ettl_logger_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s expected %0h seen %0h", n, e, g); end end
// ============================================================
// Self-checking bench for the event time-tag logger.
module ettl_logger_test;
  logic clk_i = 1'b0, rst_i = 1'b1, pin, p1v = 1'b0, p2v = 1'b0, vreq = 1'b0, cmd = 1'b0;
  logic [63:0] tbase = 64'h0, tick = 64'h0, view_time, out_time, stk [8];
  wire  [63:0] time_now_i = tbase + tick;
  logic [7:0]  p1c = 8'h00, p2c = 8'h00;
  logic [3:0]  vidx = 4'h0, cnt = 4'h0, count, out_index;
  logic        view_valid, out_valid, out_done, busy;
  logic [67:0] expq [$], e;
  int          checks = 0, n_fail = 0, i;
  // Clock at 100 MHz and a free-running time counter that steps once per clock cycle.
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) #1 tick <= tick + 64'h1;
  ettl_pulse_src src_inst (.clk_i(clk_i), .pulse_o(pin));
  ettl_logger ettl_logger_inst (.clk_i(clk_i), .rst_i(rst_i), .event_pulse_input_i(pin),
    .time_now_i(time_now_i), .port1_char_valid_i(p1v), .port1_char_i(p1c),
    .port2_char_valid_i(p2v), .port2_char_i(p2c), .view_req_i(vreq), .view_index_i(vidx),
    .read_events_command_i(cmd), .view_valid_o(view_valid), .view_time_o(view_time),
    .out_valid_o(out_valid), .out_index_o(out_index), .out_time_o(out_time),
    .out_done_o(out_done), .count_o(count), .busy_o(busy));
  // Reference stack: newest in position one, oldest dropped.
  task automatic push(input logic [63:0] t);
    for (int k = 7; k > 0; k--) stk[k] = stk[k-1];
    stk[0] = t;
    if (cnt < 4'h8) cnt++;
  endtask
  // One character on a chosen port.
  task automatic mark(input bit p2, input logic [7:0] c);
    @(posedge clk_i) #1;
    if (p2) begin p2v = 1'b1; p2c = c; end else begin p1v = 1'b1; p1c = c; end
    #1 if (c == ettl_pkg::MARK_CHAR) push(time_now_i);
    @(posedge clk_i) #1 p1v = 1'b0;
    p2v = 1'b0;
    repeat (20) @(posedge clk_i);
  endtask
  // One pin pulse; the time at the latch edge, a fixed latency after the rise, is logged.
  task automatic pin_ev();
    fork
      src_inst.fire();
      begin
        @(posedge clk_i);
        #2 push(time_now_i + 64'(ettl_pkg::PIN_LATENCY - 1));
      end
    join
  endtask
  // Views one position; an index outside one to eight must give no answer.
  task automatic view(input logic [3:0] x);
    @(posedge clk_i) #1 vreq = 1'b1;
    vidx = x;
    if (x >= 4'h1 && x <= 4'h8) expq.push_back({4'h0, stk[x-1]});
    @(posedge clk_i) #1 vreq = 1'b0;
    if (x < 4'h1 || x > 4'h8) `CHK("view_valid", 1'b0, view_valid)
  endtask
  // Full read-out, then the stack must come back empty.
  task automatic read_all();
    int k;
    @(posedge clk_i) #1 cmd = 1'b1;
    for (k = 0; k < 8; k++) expq.push_back({4'(k + 1), stk[k]});
    @(posedge clk_i) #1 cmd = 1'b0;
    `CHK("busy", 1'b1, busy)
    for (k = 0; k < 40 && out_done !== 1'b1; k++) @(posedge clk_i) #1;
    `CHK("done", 1'b1, out_done)
    `CHK("idle", 1'b0, busy)
    stk = '{default: 64'h0};
    cnt = 4'h0;
  endtask
  // Lets updates settle and compares the entry count.
  task automatic chk_count();
    repeat (6) @(posedge clk_i);
    #1 `CHK("count", cnt, count)
  endtask
  // Watcher: samples settled outputs at the falling edge; each answer takes the oldest note.
  always @(negedge clk_i) if (view_valid === 1'b1 || out_valid === 1'b1) begin
    `CHK("pending", 1'b1, expq.size() != 0)
    e = (expq.size() != 0) ? expq.pop_front() : 68'h0;
    `CHK("time", e[63:0], (view_valid === 1'b1) ? view_time : out_time)
    if (out_valid === 1'b1) `CHK("index", e[67:64], out_index)
  end
  // Verdict in one place.
  task automatic tally_and_finish();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Watchdog at about three times the expected run of some six thousand cycles.
  initial begin #200_000 n_fail++; tally_and_finish(); end
  // Main sequence.
  initial begin
    void'($urandom(92));
    stk = '{default: 64'h0};
    tbase = {$urandom, $urandom} >> 2;
    repeat (5) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk_count();
    mark(0, ettl_pkg::MARK_CHAR);
    mark(1, ettl_pkg::MARK_CHAR);
    mark($urandom % 2, 8'h41 + 8'($urandom % 26));
    chk_count();
    for (i = 0; i < 8; i++) pin_ev();
    chk_count();
    for (i = 0; i < 10; i++) view(4'(i));
    chk_count();
    read_all();
    chk_count();
    view(4'h1);
    mark(1, ettl_pkg::MARK_CHAR);
    chk_count();
    @(posedge clk_i) #1 rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1 rst_i = 1'b0;
    stk = '{default: 64'h0};
    cnt = 4'h0;
    chk_count();
    view(4'h1);
    repeat (4) @(posedge clk_i);
    `CHK("drained", 0, expq.size())
    tally_and_finish();
  end
endmodule

// >>> verification/ettl_pulse_src.sv
`timescale 1ns/1ps
// ============================================================
// Model of the user's system that drives the event pin.
module ettl_pulse_src #(
  parameter int HOLD = 500,
  parameter int GAP  = 700
) (
  input  wire logic clk_i,
  output logic      pulse_o
);
  // Pin level; it idles low between pulses.
  logic level = 1'b0;
  assign pulse_o = level;
  // One pulse, raised just after an edge, then a quiet gap.
  task automatic fire();
    @(posedge clk_i) #1 level = 1'b1;
    repeat (HOLD) @(posedge clk_i);
    #1 level = 1'b0;
    repeat (GAP - HOLD) @(posedge clk_i);
  endtask
endmodule
